//--- rtl/dma_channel_controller.sv
// paired source/destination dma channel with register and descriptor modes
// Functional notes
// - engine runs whole transfer without processor
// - source channel reads, destination channel writes
// - register mode starts without descriptor fetch
// - register mode may reload original setup
// - descriptor mode fetches, then chains next
// - linear buffer halts after last element
// - stride may be negative, positive, zero
// - circular buffer restarts in register mode only, interrupts when full
// - fractional interrupts at half, quarter or eighth
// - ping-pong ring of two-word descriptors
// - linked list of four-word descriptors
// - 2D array of one-word address descriptors
// - 2D linked list of full descriptors
// - start on trigger from another channel
`timescale 1ns/1ps
module dma_channel_controller (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // setup and start
  input wire dma_pkg::cfg_t cfg,
  input wire logic start,
  input wire logic trig_in,
  // memory port
  output dma_pkg::mreq_t mem,
  input wire logic mem_ack,
  input wire logic [dma_pkg::AW-1:0] mem_rdata,
  // status and events
  output logic busy,
  output logic irq,
  output logic trig_out
);

  dma_pkg::st_t q;
  dma_pkg::st_t d;
  logic go;
  logic [2:0] slot;
  logic last_w;

  // signed element step, shared by both channels
  function automatic logic [dma_pkg::AW-1:0] step(
    input logic [dma_pkg::AW-1:0] a,
    input logic [dma_pkg::CW-1:0] m);
    step = a + {{(dma_pkg::AW-dma_pkg::CW){m[dma_pkg::CW-1]}}, m};
  endfunction

  // elements between interrupts; frac 1 halves, 2 quarters
  function automatic logic [31:0] period(
    input logic [dma_pkg::CW-1:0] xc,
    input logic [dma_pkg::CW-1:0] yc,
    input logic [1:0] fr);
    logic [31:0] t;
    t = 32'(xc) * 32'(yc);
    period = t >> fr;
  endfunction

  // descriptor length for a format
  function automatic logic [2:0] nwords(input logic [1:0] f);
    unique case (f)
      dma_pkg::DF_RING2: nwords = dma_pkg::N_RING2;
      dma_pkg::DF_LIST4: nwords = dma_pkg::N_LIST4;
      dma_pkg::DF_ARRAY1: nwords = dma_pkg::N_ARRAY1;
      default: nwords = dma_pkg::N_LIST2D;
    endcase
  endfunction

  // a one-word descriptor holds only the address slot
  assign slot = (q.fmt == dma_pkg::DF_ARRAY1) ? dma_pkg::W_ADDR : q.wi;
  assign last_w = (q.wi == nwords(q.fmt) - 3'h1);
  assign go = (q.st == dma_pkg::S_IDLE) && (start || (cfg.trig_en && trig_in));

  // next-state logic
  // autonomous sequencer
  always_comb begin
    d = q;
    d.irq = 1'b0;
    d.trig = 1'b0;
    unique case (q.st)
      dma_pkg::S_IDLE: begin
        if (go) begin
          // setup registers also serve as retained values for descriptors
          d.busy = 1'b1;
          d.de = cfg.desc_en;
          d.fmt = cfg.fmt;
          d.sa = cfg.src;
          d.xc = cfg.xcnt;
          d.xl = cfg.xcnt;
          d.xm = cfg.xmod;
          d.yc = cfg.ycnt;
          d.yl = cfg.ycnt;
          d.ym = cfg.ymod;
          d.circ = cfg.circ;
          d.frac = cfg.frac;
          d.stop = 1'b0;
          d.fl = period(cfg.xcnt, cfg.ycnt, cfg.frac);
          d.da = cfg.dst;
          d.ptr = cfg.dptr;
          d.al = cfg.alen;
          d.wi = 3'h0;
          if (cfg.desc_en) begin
            d.st = dma_pkg::S_FETCH;
            d.m = '{1'b1, 1'b0, cfg.dptr, '0};
          end else begin
            d.st = dma_pkg::S_READ;
            d.m = '{1'b1, 1'b0, cfg.src, '0};
          end
        end
      end
      dma_pkg::S_FETCH: begin
        if (mem_ack) begin
          // slots follow link, addr, len, cfg
          unique case (slot)
            dma_pkg::W_LINK: d.link = mem_rdata;
            dma_pkg::W_ADDR: d.sa = mem_rdata;
            dma_pkg::W_LEN: d.xc = mem_rdata[dma_pkg::CW-1:0];
            dma_pkg::W_CFG: begin
              d.stop = mem_rdata[dma_pkg::CF_STOP];
              d.frac = mem_rdata[dma_pkg::CF_FRAC +: 2];
              d.circ = mem_rdata[dma_pkg::CF_CIRC];
            end
            dma_pkg::W_XMOD: d.xm = mem_rdata[dma_pkg::CW-1:0];
            dma_pkg::W_YCNT: d.yc = mem_rdata[dma_pkg::CW-1:0];
            default: d.ym = mem_rdata[dma_pkg::CW-1:0];
          endcase
          if (last_w) begin
            // unfetched fields keep their register values
            d.xl = d.xc;
            d.yl = d.yc;
            d.fl = period(d.xc, d.yc, d.frac);
            d.st = dma_pkg::S_READ;
            d.m = '{1'b1, 1'b0, d.sa, '0};
          end else begin
            d.wi = q.wi + 3'h1;
            d.m.addr = q.m.addr + dma_pkg::WORD_BYTES;
          end
        end
      end
      dma_pkg::S_READ: begin
        if (mem_ack) begin
          // destination channel writes what source read
          d.st = dma_pkg::S_WRITE;
          d.m = '{1'b1, 1'b1, q.da, mem_rdata};
        end
      end
      dma_pkg::S_WRITE: begin
        if (mem_ack) begin
          d.da = step(q.da, cfg.dmod);
          d.fl = q.fl - dma_pkg::FL_ONE;
          if (q.fl == dma_pkg::FL_ONE) begin
            d.irq = 1'b1;
            d.fl = period(q.xc, q.yc, q.frac);
          end
          d.m = '{1'b1, 1'b0, q.sa, '0};
          d.st = dma_pkg::S_READ;
          if (q.xl > dma_pkg::CNT_ONE) begin
            d.sa = step(q.sa, q.xm);
            d.xl = q.xl - dma_pkg::CNT_ONE;
            d.m.addr = d.sa;
          end else if (q.yl > dma_pkg::CNT_ONE) begin
            d.sa = step(q.sa, q.ym);
            d.xl = q.xc;
            d.yl = q.yl - dma_pkg::CNT_ONE;
            d.m.addr = d.sa;
          end else begin
            d.irq = 1'b1;
            d.trig = 1'b1;
            d.m.req = 1'b0;
            d.st = dma_pkg::S_NEXT;
          end
        end
      end
      default: begin
        d.st = dma_pkg::S_IDLE;
        d.busy = 1'b0;
        if (!q.de) begin
          if (q.circ || cfg.reload) begin
            d.sa = cfg.src;
            d.xl = cfg.xcnt;
            d.yl = cfg.ycnt;
            d.fl = period(cfg.xcnt, cfg.ycnt, cfg.frac);
            d.da = cfg.dst;
            d.busy = 1'b1;
            d.st = dma_pkg::S_READ;
            d.m = '{1'b1, 1'b0, cfg.src, '0};
          end
        end else if (!q.stop) begin
          // chain next descriptor; array walks by address
          d.wi = 3'h0;
          d.busy = 1'b1;
          d.st = dma_pkg::S_FETCH;
          if (q.fmt == dma_pkg::DF_ARRAY1) begin
            d.ptr = q.ptr + dma_pkg::WORD_BYTES;
            d.al = q.al - dma_pkg::CNT_ONE;
          end else begin
            d.ptr = q.link;
          end
          d.m = '{1'b1, 1'b0, d.ptr, '0};
          // array ends after its last entry
          if (q.fmt == dma_pkg::DF_ARRAY1 && q.al <= dma_pkg::CNT_ONE) begin
            d.busy = 1'b0;
            d.st = dma_pkg::S_IDLE;
            d.m.req = 1'b0;
          end
        end
      end
    endcase
  end

  // state register; ce low freezes everything, so acks must wait for ce
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  // outputs straight from the state register
  assign mem = q.m;
  assign busy = q.busy;
  assign irq = q.irq;
  assign trig_out = q.trig;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b || !ce);

  sequence el_step;
    q.st == dma_pkg::S_WRITE && mem_ack && q.xl > dma_pkg::CNT_ONE;
  endsequence

  sequence buf_end;
    q.trig && !q.de && !cfg.circ && !cfg.reload;
  endsequence

  sequence frac_hit;
    q.st == dma_pkg::S_WRITE && mem_ack && q.fl == dma_pkg::FL_ONE;
  endsequence

  a_irq_pulse: assert property (q.irq |=> !q.irq)
    else $error("interrupt pulse longer than one cycle");
  a_trig_pulse: assert property (q.trig |=> !q.trig)
    else $error("trigger pulse longer than one cycle");
  a_trig_irq: assert property (q.trig |-> q.irq && q.st == dma_pkg::S_NEXT)
    else $error("buffer end without interrupt");
  a_req_hold: assert property (q.m.req && !mem_ack |=> q.m.req && $stable(q.m.addr))
    else $error("request dropped before ack");
  a_write_data: assert property (q.st == dma_pkg::S_READ && mem_ack
    |=> q.m.we && q.m.req && q.m.wdata == $past(mem_rdata))
    else $error("read word not written");
  a_reg_start: assert property (go && !cfg.desc_en
    |=> q.st == dma_pkg::S_READ && !q.m.we && q.m.addr == $past(cfg.src))
    else $error("register start fetched or misaddressed");
  a_desc_start: assert property (go && cfg.desc_en
    |=> q.st == dma_pkg::S_FETCH && q.m.addr == $past(cfg.dptr))
    else $error("descriptor fetch not at pointer");
  a_fetch_order: assert property (q.st == dma_pkg::S_FETCH && mem_ack && !last_w
    |=> q.m.addr == $past(q.m.addr) + dma_pkg::WORD_BYTES)
    else $error("descriptor words not consecutive");
  a_stride_step: assert property (el_step |=> q.m.addr == step($past(q.sa), $past(q.xm)))
    else $error("wrong element stride");
  a_linear_stop: assert property (buf_end |=> q.st == dma_pkg::S_IDLE && !q.busy)
    else $error("linear buffer did not halt");
  a_circ_again: assert property (q.st == dma_pkg::S_NEXT && !q.de && cfg.circ
    |=> q.st == dma_pkg::S_READ && q.m.addr == $past(cfg.src))
    else $error("circular buffer did not restart");
  a_chain_link: assert property (q.st == dma_pkg::S_NEXT && q.de && !q.stop
    && q.fmt != dma_pkg::DF_ARRAY1 |=> q.st == dma_pkg::S_FETCH && q.m.addr == $past(q.link))
    else $error("link pointer not followed");
  a_trig_go: assert property (q.st == dma_pkg::S_IDLE && cfg.trig_en && trig_in
    |=> q.busy ##1 q.m.req)
    else $error("trigger did not start channel");
  // busy must track the sequencer, otherwise a waiting channel could miss its start
  a_busy_state: assert property ((q.st == dma_pkg::S_IDLE) == !q.busy)
    else $error("busy flag disagrees with state");
  a_idle_quiet: assert property (q.st == dma_pkg::S_IDLE |-> !q.m.req)
    else $error("idle engine holds a request");
  a_frac_irq: assert property (frac_hit |=> q.irq)
    else $error("fraction boundary without interrupt");
  a_desc_stop: assert property (q.st == dma_pkg::S_NEXT && q.de && q.stop
    |=> q.st == dma_pkg::S_IDLE && !q.busy && !q.m.req)
    else $error("stopped descriptor chain kept running");
  a_reload_again: assert property (q.st == dma_pkg::S_NEXT && !q.de && cfg.reload
    |=> q.st == dma_pkg::S_READ && q.m.addr == $past(cfg.src))
    else $error("register setup not reloaded");
  a_array_step: assert property (q.st == dma_pkg::S_NEXT && q.de && !q.stop
    && q.fmt == dma_pkg::DF_ARRAY1 && q.al > dma_pkg::CNT_ONE
    |=> q.st == dma_pkg::S_FETCH && q.m.addr == $past(q.ptr) + dma_pkg::WORD_BYTES)
    else $error("address array not walked");

endmodule // dma_channel_controller

//--- rtl/dma_pkg.sv
// shared constants and types of the dma channel controller
package dma_pkg;
  localparam int AW = 32;
  localparam int CW = 16;
  // descriptor formats
  localparam logic [1:0] DF_RING2 = 2'h0;
  localparam logic [1:0] DF_LIST4 = 2'h1;
  localparam logic [1:0] DF_ARRAY1 = 2'h2;
  localparam logic [1:0] DF_LIST2D = 2'h3;
  // descriptor word slots, in fetch order
  localparam logic [2:0] W_LINK = 3'h0;
  localparam logic [2:0] W_ADDR = 3'h1;
  localparam logic [2:0] W_LEN = 3'h2;
  localparam logic [2:0] W_CFG = 3'h3;
  localparam logic [2:0] W_XMOD = 3'h4;
  localparam logic [2:0] W_YCNT = 3'h5;
  localparam logic [2:0] W_YMOD = 3'h6;
  // words per descriptor
  localparam logic [2:0] N_RING2 = 3'h2;
  localparam logic [2:0] N_LIST4 = 3'h4;
  localparam logic [2:0] N_ARRAY1 = 3'h1;
  localparam logic [2:0] N_LIST2D = 3'h7;
  // configuration word fields
  localparam int CF_STOP = 0;
  localparam int CF_FRAC = 1;
  localparam int CF_CIRC = 3;
  // byte step between descriptor words
  localparam logic [AW-1:0] WORD_BYTES = 32'h4;
  localparam logic [CW-1:0] CNT_ONE = 16'h1;
  localparam logic [31:0] FL_ONE = 32'h1;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_FETCH = 3'h1,
    S_READ = 3'h3,
    S_WRITE = 3'h2,
    S_NEXT = 3'h6
  } state_t;

  // channel setup as software leaves it
  typedef struct packed {
    logic desc_en;
    logic [1:0] fmt;
    logic circ;
    logic reload;
    logic trig_en;
    logic [1:0] frac;
    logic [AW-1:0] src;
    logic [CW-1:0] xcnt;
    logic [CW-1:0] xmod;
    logic [CW-1:0] ycnt;
    logic [CW-1:0] ymod;
    logic [AW-1:0] dst;
    logic [CW-1:0] dmod;
    logic [AW-1:0] dptr;
    logic [CW-1:0] alen;
  } cfg_t;

  // memory request
  typedef struct packed {
    logic req;
    logic we;
    logic [AW-1:0] addr;
    logic [AW-1:0] wdata;
  } mreq_t;

  // whole engine state
  typedef struct packed {
    state_t st;
    logic de;
    logic [1:0] fmt;
    logic [AW-1:0] ptr;
    logic [2:0] wi;
    logic [AW-1:0] link;
    logic [AW-1:0] sa;
    logic [CW-1:0] xl;
    logic [CW-1:0] yl;
    logic [CW-1:0] xc;
    logic [CW-1:0] yc;
    logic [CW-1:0] xm;
    logic [CW-1:0] ym;
    logic stop;
    logic circ;
    logic [1:0] frac;
    logic [31:0] fl;
    logic [AW-1:0] da;
    logic [CW-1:0] al;
    mreq_t m;
    logic irq;
    logic trig;
    logic busy;
  } st_t;
endpackage

//--- tb/dma_mem_model.sv
// memory and peripheral side model answering the engine's requests
`timescale 1ns/1ps
module dma_mem_model (
  // clock, reset and enable
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // memory port
  input wire dma_pkg::mreq_t mem,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [31:0] ram [0:255];
  logic [1:0] wait_q;
  // one request at a time, after a random wait of zero to two cycles
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_ack <= 1'b0;
      wait_q <= 2'h0;
      mem_rdata <= 32'h0;
    end else if (mem_ack) begin
      // an ack lost to ce low lands its write on the repeat
      if (ce && mem.we) ram[mem.addr[9:2]] <= mem.wdata;
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end else if (mem.req && wait_q == 2'h0) begin
      mem_ack <= 1'b1;
      mem_rdata <= ram[mem.addr[9:2]];
      wait_q <= 2'($urandom % 3);
    end else begin
      // read data is not held once the ack is gone
      mem_rdata <= ~mem_rdata;
      if (wait_q != 2'h0) wait_q <= wait_q - 2'h1;
    end
  end
endmodule // dma_mem_model

//--- tb/dma_channel_controller_tb.sv
// self-checking bench of the dma channel controller
`timescale 1ns/1ps
module dma_channel_controller_tb;
  typedef struct packed {logic we; logic [31:0] addr; logic [31:0] data;} exp_t;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic start = 1'b0;
  logic trig_in = 1'b0;
  logic endless = 1'b0;
  logic hold = 1'b0;
  logic irq_p = 1'b0;
  logic busy, irq, trig_out, mem_ack;
  logic [31:0] mem_rdata;
  dma_pkg::mreq_t mem;
  dma_pkg::cfg_t cf = '0;
  exp_t exp_q[$];
  exp_t e;
  int n_fail = 0;
  int check_count = 0;
  int n_irq = 0;
  int n_trig = 0;
  int stp[3] = '{4, -4, 0};
  int a2[4] = '{0, 4, 12, 16};
  // free-running clock
  always #5 clk = ~clk;
  dma_channel_controller dut_u (.clk(clk), .rst_b(rst_b), .ce(ce), .cfg(cf), .start(start), .trig_in(trig_in),
    .mem(mem), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .busy(busy), .irq(irq), .trig_out(trig_out));
  dma_mem_model mem_u (.clk(clk), .rst_b(rst_b), .ce(ce), .mem(mem), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    check_count++;
    if (seen !== want) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic stop_test;
    $display("comparisons=%0d mismatches=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // each element is a read of s, then a write of that word to d
  task automatic elem(input logic [31:0] s, input logic [31:0] d);
    exp_q.push_back({1'b0, s, 32'h0});
    exp_q.push_back({1'b1, d, mem_u.ram[s[9:2]]});
  endtask
  task automatic desc(input logic [31:0] p, input int n);
    for (int i = 0; i < n; i++) exp_q.push_back({1'b0, p + 32'(4 * i), 32'h0});
  endtask
  task automatic put(input int at, input logic [31:0] w[$]);
    foreach (w[i]) mem_u.ram[at + i] = w[i];
  endtask
  task automatic base(input logic [31:0] s, input int xc, input int xm, input int yc, input int ym);
    cf = '0;
    cf.src = s;
    cf.xcnt = 16'(xc);
    cf.xmod = 16'(xm);
    cf.ycnt = 16'(yc);
    cf.ymod = 16'(ym);
    cf.dst = 32'h200;
    cf.dmod = 16'h4;
  endtask
  task automatic dm(input logic [1:0] f, input logic [31:0] p);
    cf.desc_en = 1'b1;
    cf.fmt = f;
    cf.dptr = p;
    cf.alen = 16'h2;
  endtask
  // start, poke start while busy, wait for the expected traffic, then count events
  task automatic go(input int irqs, input int trigs, input logic by_trig);
    n_irq = 0;
    n_trig = 0;
    if (by_trig) trig_in = 1'b1;
    else start = 1'b1;
    @(negedge clk);
    trig_in = 1'b0;
    start = 1'b0;
    check(busy, 1);
    for (int i = 0; i < 600 && (exp_q.size() > 0 || (busy && !endless)); i++) begin
      ce = !(hold && i < 4);
      start = (i == 2);
      @(negedge clk);
    end
    ce = 1'b1;
    start = 1'b0;
    if (exp_q.size() > 0 || (busy && !endless)) begin
      check(1, 0);
      stop_test();
    end
    repeat (3) @(negedge clk);
    check(n_irq, irqs);
    check(n_trig, trigs);
    if (endless) begin
      rst_b = 1'b0;
      @(negedge clk);
      rst_b = 1'b1;
      endless = 1'b0;
    end
  endtask
  // compare each completed request with the oldest note, except those past the last note of an endless run; count event pulses
  always @(posedge clk) begin
    if (rst_b && ce && mem_ack && mem.req && !(endless && exp_q.size() == 0)) begin
      if (exp_q.size() == 0) check(1, 0);
      else begin
        e = exp_q.pop_front();
        check({mem.we, mem.addr}, {e.we, e.addr});
        if (e.we) check(mem.wdata, e.data);
      end
    end
    if (rst_b) begin
      n_irq += int'(irq);
      n_trig += int'(trig_out);
      if (trig_out) check(irq, 1);
      if (irq_p) check(irq, 0);
    end
    irq_p <= irq;
  end
  initial begin
    void'($urandom(32'h4EAC));
    for (int i = 0; i < 256; i++) mem_u.ram[i] = $urandom;
    repeat (5) @(negedge clk);
    rst_b = 1'b1;
    foreach (stp[k]) begin
      base(32'h180, 3, stp[k], 1, 0);
      for (int i = 0; i < 3; i++) elem(32'(32'h180 + i * stp[k]), 32'(32'h200 + 4 * i));
      hold = (k == 0);
      go(1, 1, 1'b0);
      hold = 1'b0;
    end
    for (int f = 0; f < 3; f++) begin
      base(32'h100, 2, 4, 2, 8);
      cf.frac = 2'(f);
      foreach (a2[j]) elem(32'h100 + 32'(a2[j]), 32'(32'h200 + 4 * j));
      go(1 << f, 1, 1'b0);
    end
    for (int m = 0; m < 2; m++) begin
      base(32'h120, 2, 4, 1, 0);
      cf.circ = (m == 0);
      cf.reload = (m == 1);
      endless = 1'b1;
      repeat (2) begin
        elem(32'h120, 32'h200);
        elem(32'h124, 32'h204);
      end
      go(2, 2, 1'b0);
    end
    base(32'h140, 1, 4, 1, 0);
    trig_in = 1'b1;
    repeat (3) @(negedge clk);
    trig_in = 1'b0;
    check(busy, 0);
    cf.trig_en = 1'b1;
    elem(32'h140, 32'h200);
    go(1, 1, 1'b1);
    put(0, '{32'h40, 32'h100, 32'h2, 32'h0});
    put(16, '{32'h0, 32'h140, 32'h1, 32'h1});
    base(32'h0, 1, 4, 1, 0);
    dm(dma_pkg::DF_LIST4, 32'h0);
    desc(32'h0, 4);
    elem(32'h100, 32'h200);
    elem(32'h104, 32'h204);
    desc(32'h40, 4);
    elem(32'h140, 32'h208);
    go(2, 2, 1'b0);
    put(32, '{32'h88, 32'h180, 32'h80, 32'h1C0});
    base(32'h0, 2, 4, 1, 0);
    dm(dma_pkg::DF_RING2, 32'h80);
    endless = 1'b1;
    for (int j = 0; j < 2; j++) begin
      desc(32'h80 + 32'(8 * j), 2);
      for (int k = 0; k < 2; k++) elem(mem_u.ram[33 + 2 * j] + 32'(4 * k), 32'(32'h200 + 8 * j + 4 * k));
    end
    go(2, 2, 1'b0);
    put(36, '{32'h110, 32'h130});
    base(32'h0, 2, 4, 2, 4);
    dm(dma_pkg::DF_ARRAY1, 32'h90);
    for (int j = 0; j < 2; j++) begin
      desc(32'h90 + 32'(4 * j), 1);
      for (int k = 0; k < 4; k++) elem(mem_u.ram[36 + j] + 32'(4 * k), 32'(32'h200 + 16 * j + 4 * k));
    end
    go(2, 2, 1'b0);
    put(40, '{32'h0, 32'h160, 32'h2, 32'h1, 32'hFFFC, 32'h2, 32'h10});
    base(32'h0, 1, 0, 1, 0);
    dm(dma_pkg::DF_LIST2D, 32'hA0);
    desc(32'hA0, 7);
    elem(32'h160, 32'h200);
    elem(32'h15C, 32'h204);
    elem(32'h16C, 32'h208);
    elem(32'h168, 32'h20C);
    go(1, 1, 1'b0);
    stop_test();
  end
endmodule // dma_channel_controller_tb
